// *** hdl/ass_params.svh ***
// timing constants for the analog sample sequencer strobe block
// assumes sys_clk figures below match the actual clock
`ifndef ASS_PARAMS_SVH
`define ASS_PARAMS_SVH
`define ASS_SYS_CLK_HZ       250000000
`define ASS_STROBE_LOW_NS    5000
`define ASS_CUR_HIGH_NS      5000
`define ASS_TEMP_HIGH_NS     10000
`define ASS_TEMP_SETTLE_NS   5000
`define ASS_TURNAROUND_CYC   10
`define ASS_CNT_W            16
`endif

// *** hdl/ass_pkg.sv ***
// types for the analog sample sequencer strobe block
// assumes ass_params.svh is on the include path
package ass_pkg;
  typedef enum logic [1:0] {
    ASS_KIND_VOLT,
    ASS_KIND_CUR,
    ASS_KIND_TEMP,
    ASS_KIND_DIFF
  } ass_kind_t;

  typedef enum logic [2:0] {
    ASS_IDLE,
    ASS_LOWWAIT,
    ASS_SETTLE,
    ASS_ACQ,
    ASS_CONV,
    ASS_HOLD,
    ASS_TURN
  } ass_state_t;
endpackage : ass_pkg

// *** hdl/ass_strobe_seq.sv ***
// strobe sequencer for current, temperature and differential monitor channels
// assumes the channel schedule and the ADC run on sys_clk; adc done comes from a pin
//
// Function
// - one strobe output per monitor channel
// - strobe stays low five microseconds after fall
// - current strobe high at least five microseconds
// - temperature strobe high at least ten microseconds
// - temperature: strobe, wait five microseconds, start
// - acquisition time elapses before conversion starts
// - strobe held whole channel time, dropped on move
// - ten cycles turnaround before next start
// - strobes only for current, temperature, differential
`timescale 1ns/1ns
`include "ass_params.svh"
module ass_strobe_seq import ass_pkg::*; #(
  parameter int NCH        = 8,
  parameter int CLK_HZ     = `ASS_SYS_CLK_HZ,
  parameter int CW         = `ASS_CNT_W
) (
  // clock and reset
  input  wire logic                    sys_clk,
  input  wire logic                    nrst,
  // channel schedule
  input  wire logic                    chanReq,
  input  wire logic [$clog2(NCH)-1:0]  chanSel,
  input  wire ass_kind_t               chanKind,
  input  wire logic [CW-1:0]           acqCycles,
  output logic                         chanBusy,
  output logic                         chanDone,
  // adc and monitors
  output logic [NCH-1:0]               monStrobe,
  output logic                         adcSample,
  output logic                         adcStart,
  input  wire logic                    adcConvDone
);
  // cycles per time, rounded up since all are minimums; never below one
  function automatic longint cycRaw(input longint ns);
    longint c;
    c = (ns * longint'(CLK_HZ) + 64'd999999999) / 64'd1000000000;
    if (c < 1) c = 1;
    return c;
  endfunction : cycRaw

  // same count cut to counter width; the width check below keeps the cut lossless
  function automatic logic [CW-1:0] nsToCyc(input longint ns);
    return CW'(cycRaw(ns));
  endfunction : nsToCyc

  localparam logic [CW-1:0] LOW_CYC    = nsToCyc(`ASS_STROBE_LOW_NS);
  localparam logic [CW-1:0] CUR_CYC    = nsToCyc(`ASS_CUR_HIGH_NS);
  localparam logic [CW-1:0] TEMP_CYC   = nsToCyc(`ASS_TEMP_HIGH_NS);
  localparam logic [CW-1:0] SETTLE_CYC = nsToCyc(`ASS_TEMP_SETTLE_NS);
  localparam logic [CW-1:0] TURN_CYC   = CW'(`ASS_TURNAROUND_CYC);

  // refuse settings the logic cannot serve; the half-range margin keeps the
  // longest strobe count well away from wrap-around
  if (NCH < 2) begin : gNch
    $error("ass_strobe_seq: NCH must be at least two");
  end
  if (CLK_HZ <= 0) begin : gClk
    $error("ass_strobe_seq: CLK_HZ must be positive");
  end
  if (CW < 4 || cycRaw(`ASS_TEMP_HIGH_NS) >= (longint'(1) << (CW - 1))) begin : gCw
    $error("ass_strobe_seq: CW too narrow for the longest strobe time");
  end
  if (`ASS_TURNAROUND_CYC < 2) begin : gTurn
    $error("ass_strobe_seq: turnaround count must be at least two");
  end

  typedef struct packed {
    ass_state_t             state;
    logic [$clog2(NCH)-1:0] chan;
    logic                   needStrobe;
    logic [CW-1:0]          highLeft;
    logic [NCH-1:0]         strobe;
    logic                   busy;
    logic                   done;
    logic                   sample;
    logic                   start;
    logic [1:0]             convSync;
    // per-channel low-time counters, one per strobe
    logic [NCH-1:0][CW-1:0] lowLeft;
  } ass_seq_st_t;

  ass_seq_st_t st, next_st;

  ass_timer_if #(.W(CW)) tif ();

  ass_timer #(.W(CW)) phaseTimer (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .tif     (tif.timer)
  );

  function automatic logic isStrobed(input ass_kind_t k);
    return (k == ASS_KIND_CUR) || (k == ASS_KIND_TEMP) || (k == ASS_KIND_DIFF);
  endfunction : isStrobed

  function automatic logic isTemp(input ass_kind_t k);
    return k == ASS_KIND_TEMP;
  endfunction : isTemp

  // count down to zero and rest there
  function automatic logic [CW-1:0] decSat(input logic [CW-1:0] v);
    return (v != '0) ? v - CW'(1) : v;
  endfunction : decSat

  logic convDone;
  assign convDone = st.convSync[1];

  always_comb begin
    next_st      = st;
    tif.load     = 1'b0;
    tif.value    = '0;
    next_st.done  = 1'b0;
    next_st.start = 1'b0;
    next_st.convSync = {st.convSync[0], adcConvDone};
    // high and low minimums run on plain cycle counters of sys_clk
    next_st.highLeft = decSat(st.highLeft);
    for (int i = 0; i < NCH; i++) begin
      next_st.lowLeft[i] = decSat(st.lowLeft[i]);
    end
    case (st.state)
      ASS_IDLE: begin
        // one request at a time; later ones are ignored until chanDone
        if (chanReq) begin
          next_st.chan       = chanSel;
          next_st.needStrobe = isStrobed(chanKind);
          next_st.busy       = 1'b1;
          next_st.state      = ASS_LOWWAIT;
        end
      end
      ASS_LOWWAIT: begin
        if (!st.needStrobe) begin
          next_st.state = ASS_ACQ;
          tif.load      = 1'b1;
          tif.value     = acqCycles;
          next_st.sample = 1'b1;
        end else if (st.lowLeft[st.chan] == '0) begin
          // a strobe may rise only once its low time has run out
          next_st.strobe[st.chan] = 1'b1;
          next_st.highLeft = isTemp(chanKind) ? TEMP_CYC : CUR_CYC;
          if (isTemp(chanKind)) begin
            next_st.state = ASS_SETTLE;
            tif.load      = 1'b1;
            tif.value     = SETTLE_CYC;
          end else begin
            next_st.state  = ASS_ACQ;
            tif.load       = 1'b1;
            tif.value      = acqCycles;
            next_st.sample = 1'b1;
          end
        end
      end
      ASS_SETTLE: begin
        // the temperature monitor settles with its strobe already high
        if (tif.done) begin
          next_st.state  = ASS_ACQ;
          tif.load       = 1'b1;
          tif.value      = acqCycles;
          next_st.sample = 1'b1;
        end
      end
      ASS_ACQ: begin
        // start is a one-cycle pulse on the edge where sampling ends
        if (tif.done) begin
          next_st.sample = 1'b0;
          next_st.start  = 1'b1;
          next_st.state  = ASS_CONV;
        end
      end
      ASS_CONV: begin
        // conversion done comes through the two-stage synchroniser
        if (convDone) begin
          next_st.state = ASS_HOLD;
        end
      end
      ASS_HOLD: begin
        // strobe kept for the whole channel time, never released early
        if (st.highLeft == '0 || !st.needStrobe) begin
          if (st.needStrobe) begin
            next_st.strobe[st.chan] = 1'b0;
            next_st.lowLeft[st.chan] = LOW_CYC;
          end
          next_st.state = ASS_TURN;
          // the timer's count-zero cycle and the idle entry are two of the turnaround cycles
          tif.load      = 1'b1;
          tif.value     = TURN_CYC - CW'(2);
        end
      end
      ASS_TURN: begin
        // chanDone ends the turnaround and frees the schedule side
        if (tif.done) begin
          next_st.state = ASS_IDLE;
          next_st.busy  = 1'b0;
          next_st.done  = 1'b1;
        end
      end
      default: begin
        next_st = '0;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign monStrobe = st.strobe;
  assign adcSample = st.sample;
  assign adcStart  = st.start;
  assign chanBusy  = st.busy;
  assign chanDone  = st.done;
endmodule : ass_strobe_seq

// *** hdl/ass_timer.sv ***
// countdown timer: load a cycle count, done is high once it has run out
// assumes load pulses come from logic on sys_clk
`timescale 1ns/1ns
module ass_timer #(parameter int W = 16) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // control
  ass_timer_if.timer tif
);
  typedef struct packed {
    logic [W-1:0] count;
  } ass_tmr_st_t;

  ass_tmr_st_t st, next_st;

  always_comb begin
    next_st = st;
    if (tif.load) begin
      next_st.count = tif.value;
    end else if (st.count != '0) begin
      next_st.count = st.count - W'(1);
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // done reads the count only, so a load decided on done forms no loop
  assign tif.done = (st.count == '0);
endmodule : ass_timer

// *** hdl/ass_timer_if.sv ***
// interface between the sequencer and its countdown timer
// assumes one clock domain shared by both ends
`timescale 1ns/1ns
interface ass_timer_if #(parameter int W = 16);
  logic         load;
  logic [W-1:0] value;
  logic         done;
  modport ctrl  (output load, output value, input done);
  modport timer (input load, input value, output done);
endinterface : ass_timer_if

// *** testbench/ass_adc_model.sv ***
// adc model: raises conversion done a set number of cycles after each start
// assumes start pulses on sys_clk; lat of at least four
`timescale 1ns/1ns
module ass_adc_model (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic nrst,
  // adc handshake
  input  wire logic [31:0] lat,
  input  wire logic adcStart,
  output logic      adcConvDone
);
  int cnt;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cnt <= 0;
      adcConvDone <= 1'b0;
    end else begin
      cnt <= adcStart ? lat : (cnt > 0 ? cnt - 1 : 0);
      // held three cycles so the synchroniser sees it
      adcConvDone <= cnt > 0 && cnt <= 3;
    end
  end
endmodule : ass_adc_model

// *** testbench/ass_strobe_properties.sv ***
// checker for strobe timing at the sequencer ports
// assumes a bind from the bench and one clock domain
`timescale 1ns/1ns
module ass_strobe_properties import ass_pkg::*; #(
  parameter int NCH    = 8,
  parameter int CLK_HZ = 250000000
) (
  // clock and reset
  input wire logic           sys_clk,
  input wire logic           nrst,
  // watched ports
  input wire logic           chanReq,
  input wire logic           chanBusy,
  input wire logic           chanDone,
  input wire ass_kind_t      chanKind,
  input wire logic [NCH-1:0] monStrobe,
  input wire logic           adcSample,
  input wire logic           adcStart
);
  localparam int LO = CLK_HZ / 200000;
  localparam int HT = CLK_HZ / 100000;
  logic [15:0] hiCnt;
  logic [15:0] loCnt [NCH];
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  sequence sampEnd;
    adcSample ##1 !adcSample;
  endsequence
  // cycles high of the live strobe, cycles low of each strobe
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      hiCnt <= 16'h0;
      for (int i = 0; i < NCH; i++) loCnt[i] <= 16'hffff;
    end else begin
      hiCnt <= (|monStrobe) ? hiCnt + 16'h1 : 16'h0;
      for (int i = 0; i < NCH; i++) loCnt[i] <= monStrobe[i] ? 16'h0 : loCnt[i] + {15'h0, ~&loCnt[i]};
    end
  end
  for (genvar g = 0; g < NCH; g++) begin : lowg
    chk_low_time: assert property ($rose(monStrobe[g]) |-> loCnt[g] >= LO)
      else $error("strobe rose too soon after falling");
  end
  chk_high_time: assert property ($fell(|monStrobe) |->
    hiCnt >= (chanKind == ASS_KIND_TEMP ? HT : LO)) else $error("strobe high too short");
  chk_temp_settle: assert property ($rose(adcSample) && chanKind == ASS_KIND_TEMP |->
    hiCnt >= LO) else $error("temperature sampling began before settling");
  chk_start_after: assert property (sampEnd |-> adcStart)
    else $error("no start right after sampling");
  chk_start_pulse: assert property (adcStart |=> !adcStart && !adcSample)
    else $error("start not a single pulse");
  chk_strobe_held: assert property (adcSample && chanKind != ASS_KIND_VOLT |-> |monStrobe)
    else $error("strobe low while sampling");
  chk_one_strobe: assert property ($onehot0(monStrobe))
    else $error("two strobes high");
  chk_volt_none: assert property (chanBusy && chanKind == ASS_KIND_VOLT |-> monStrobe == '0)
    else $error("strobe on a voltage channel");
  chk_turn_done: assert property ($fell(|monStrobe) |-> !chanDone ##[4:15] chanDone)
    else $error("turnaround out of range");
  chk_req_taken: assert property (chanReq && !chanBusy |=> chanBusy)
    else $error("request not taken");
endmodule : ass_strobe_properties

// *** testbench/testbench.sv ***
// self-checking bench for the strobe sequencer with an adc model
// assumes counts lowered to a 10 MHz figure: 50 cycles is 5 us
`timescale 1ns/1ns
`include "ass_params.svh"
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin bad_count++; \
  $display("wrong value at %0t: %h %h", $time, a, b); end end
module testbench import ass_pkg::*; ;
  logic sys_clk, nrst, chanReq, chanBusy, chanDone, adcSample, adcStart, adcConvDone;
  logic [2:0]  chanSel;
  logic [15:0] acqCycles;
  logic [7:0]  monStrobe;
  ass_kind_t   chanKind;
  int lat, checked, bad_count, cyc, hi, smp, other, lead, turn;
  ass_strobe_seq #(.NCH(8), .CLK_HZ(10000000)) ass_strobe_seq_i (.sys_clk(sys_clk),
    .nrst(nrst), .chanReq(chanReq), .chanSel(chanSel), .chanKind(chanKind),
    .acqCycles(acqCycles), .chanBusy(chanBusy), .chanDone(chanDone), .monStrobe(monStrobe),
    .adcSample(adcSample), .adcStart(adcStart), .adcConvDone(adcConvDone));
  ass_adc_model ass_adc_model_i (.sys_clk(sys_clk), .nrst(nrst), .lat(lat),
    .adcStart(adcStart), .adcConvDone(adcConvDone));
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish
  // one channel; a second request while busy must be ignored
  task automatic run_chan(input logic [2:0] sel, input ass_kind_t kind, input logic [15:0] acq);
    logic       done;
    logic [7:0] atDone;
    hi = 0;
    smp = 0;
    other = 0;
    lead = 0;
    turn = 0;
    @(posedge sys_clk);
    chanReq <= 1'b1;
    chanSel <= sel;
    chanKind <= kind;
    acqCycles <= acq;
    @(posedge sys_clk);
    chanSel <= sel + 3'h1;
    @(posedge sys_clk);
    chanReq <= 1'b0;
    do begin
      #1;
      lead += (hi == 0 && !monStrobe[sel]);
      hi += monStrobe[sel];
      turn += (hi > 0 && !monStrobe[sel]);
      smp += adcSample;
      other += |(monStrobe & ~(8'h1 << sel));
      done = chanDone;
      atDone = monStrobe;
      @(posedge sys_clk);
    end while (done !== 1'b1 && cyc < 19000);
    `CHK(done, 1'b1)
    `CHK(smp, acq + 1)
    `CHK(other, 0)
    `CHK(atDone, 8'h0)
    if (kind != ASS_KIND_VOLT) `CHK(turn, `ASS_TURNAROUND_CYC)
  endtask : run_chan
  task automatic test_cur_back();
    lat <= 5;
    run_chan(3'h0, ASS_KIND_CUR, 16'h4);
    `CHK(hi >= 50, 1'b1)
    run_chan(3'h0, ASS_KIND_CUR, 16'h1);
    `CHK(hi >= 50, 1'b1)
    `CHK(lead > 0, 1'b1)
  endtask : test_cur_back
  task automatic test_temp();
    lat <= 200;
    run_chan(3'h7, ASS_KIND_TEMP, 16'h32);
    `CHK(hi >= 100, 1'b1)
  endtask : test_temp
  task automatic test_diff_volt();
    lat <= 60;
    run_chan(3'h5, ASS_KIND_DIFF, 16'h3c);
    `CHK(hi >= 50, 1'b1)
    run_chan(3'h1, ASS_KIND_VOLT, 16'h8);
    `CHK(hi, 0)
    run_chan(3'h5, ASS_KIND_DIFF, 16'h3c);
    `CHK(lead, 0)
  endtask : test_diff_volt
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      tally_and_finish();
    end
  end
  initial begin
    {nrst, chanReq, chanSel, acqCycles, lat, checked, bad_count} = '0;
    chanKind = ASS_KIND_VOLT;
    repeat (16) @(posedge sys_clk);
    nrst <= 1'b1;
    test_cur_back();
    test_temp();
    test_diff_volt();
    tally_and_finish();
  end
endmodule : testbench
bind ass_strobe_seq ass_strobe_properties #(.NCH(NCH), .CLK_HZ(CLK_HZ)) ass_strobe_properties_i (
  .sys_clk(sys_clk), .nrst(nrst), .chanReq(chanReq), .chanBusy(chanBusy), .chanDone(chanDone),
  .chanKind(chanKind), .monStrobe(monStrobe), .adcSample(adcSample), .adcStart(adcStart));
